// ===== rtl/burst_wr_phase.sv
// Purpose: data phases of a 64-bit master burst write, local QWORDs to AD
// Assumes: address phase done elsewhere; start pulses once the address phase ends
// Notes: target pins pass two flops; a two-entry buffer absorbs local stalls
`timescale 1ns/10ps
`include "burst_wr_cfg.svh"

// Contract
// R01: with target claimed and local ready, pulse both half-taken strobes together
// R02: strobes stay high while no QWORD is taken
// R03: local master holds ready, data and enables until a strobe takes them
// R04: FRAME# asserted while more data phases remain
// R05: a data phase completes when IRDY# and TRDY# are both asserted
// R06: remaining count drops by one the clock after each completed phase
// R07: after a completed phase the next buffered QWORD and enables go on AD, C/BE#
// R08: IRDY# stays asserted for the next phase while data is available
// R09: on the final phase FRAME#, REQ64# and both strobes deassert
// R10: turnaround releases FRAME#, REQ64#, AD, C/BE# and deasserts IRDY#
// R11: turnaround forces the remaining count to zero
// R12: last phase completed means bus-termination status with normal end kind
// R13: target deasserts DEVSEL#, ACK64#, TRDY# in the turnaround clock
// R14: data phases run only while ACK64# is asserted, both lanes each phase
module burst_wr_phase
   import burst_wr_pkg::*;
#(
   parameter int CW = `CNT_WIDTH
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // burst start from the address-phase logic
   input  wire logic          start,
   input  wire logic [CW-1:0] burst_len,
   // local master
   input  wire logic          local_source_ready_n,
   input  wire logic [63:0]   local_data_in,
   input  wire logic [7:0]    local_byte_enables_in,
   output      logic          local_low_half_taken_n,
   output      logic          local_high_half_taken_n,
   output      logic [CW-1:0] remaining_burst_count,
   output      logic [3:0]    local_master_state_code,
   output      logic [1:0]    local_master_end_kind,
   // bus pins driven by this end
   output      logic          frame_n_o,
   output      logic          frame_oe,
   output      logic          req64_n_o,
   output      logic          req64_oe,
   output      logic          irdy_n_o,
   output      logic          irdy_oe,
   output      logic [63:0]   ad_o,
   output      logic          ad_oe,
   output      logic [7:0]    cbe_n_o,
   output      logic          cbe_oe,
   // bus pins from the target
   input  wire logic          trdy_n_i,
   input  wire logic          devsel_n_i,
   input  wire logic          ack64_n_i
);
   initial begin
      if (CW < 2) $error("burst_wr_phase: CW must be at least 2");
   end

   localparam logic [CW-1:0] ONE = CW'(1);

   phase_t        st_r;
   phase_t        st_nxt;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic [CW-1:0] fetch_r;
   logic [63:0]   ad_r;
   logic [7:0]    cbe_r;
   logic          ad_vld_r;
   logic          ad_vld_nxt;
   logic          irdy_r;
   logic          irdy_nxt;
   logic          frame_r;
   logic          frame_nxt;
   logic [3:0]    status_r;
   logic [1:0]    end_r;

   logic [2:0]    pins_s;
   logic          fill_rdy;
   logic          drain_vld;
   logic [71:0]   drain_data;

   pin_sync #(
      .W   (3),
      .RST (`SYNC_IDLE)
   ) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     ({trdy_n_i, devsel_n_i, ack64_n_i}),
      .q     (pins_s)
   );

   wire trdy_s_n   = pins_s[2];
   wire devsel_s_n = pins_s[1];
   wire ack64_s_n  = pins_s[0];

   wire in_data    = st_r == PH_DATA;
   wire in_turn    = st_r == PH_TURN;
   wire go         = (st_r == PH_IDLE) && start && (burst_len != '0);
   // R14: a 64-bit claim needs DEVSEL# and ACK64#
   wire claimed    = !devsel_s_n && !ack64_s_n;
   // R05: phase completes with both ready signals asserted
   wire done       = irdy_r && !trdy_s_n;
   wire last       = count_r == ONE;
   wire last_done  = done && last;

   // R01: take a QWORD only once claimed and the local side is ready
   wire fill_vld   = in_data && claimed && (fetch_r != '0) && !local_source_ready_n;
   wire fill       = fill_vld && fill_rdy;
   // R07: refill the AD register when empty or on a completed phase
   wire drain_rdy  = in_data && (!ad_vld_r || done) && !last_done;
   wire pop        = drain_vld && drain_rdy;

   qword_fifo #(
      .W     (72),
      .DEPTH (`FIFO_DEPTH)
   ) u_buf (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .in_vld   (fill_vld),
      .in_rdy   (fill_rdy),
      .in_data  ({local_byte_enables_in, local_data_in}),
      .out_vld  (drain_vld),
      .out_rdy  (drain_rdy),
      .out_data (drain_data)
   );

   // R01: both half strobes pulse together on a take
   // R02: high whenever nothing is taken
   assign local_low_half_taken_n  = !fill;
   assign local_high_half_taken_n = !fill;

   // R06: count drops the clock after a completed phase
   // R11: turnaround forces zero
   assign count_nxt  = go      ? burst_len :
                       in_turn ? '0 :
                       done    ? count_r - ONE : count_r;

   assign ad_vld_nxt = pop ? 1'b1 : (done ? 1'b0 : ad_vld_r);

   // R08: IRDY# stays on while data is held and the claim stands
   // R14: no phase without ACK64#
   assign irdy_nxt   = in_data && !last_done && ad_vld_nxt && claimed;

   // R04: FRAME# held while phases remain
   // R09: dropped with IRDY# on the final phase
   assign frame_nxt  = go || (in_data && !last_done && !((count_nxt == ONE) && irdy_nxt));

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         PH_IDLE: if (go) st_nxt = PH_DATA;
         PH_DATA: if (last_done) st_nxt = PH_TURN;
         PH_TURN: st_nxt = PH_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r     <= PH_IDLE;
         count_r  <= '0;
         ad_vld_r <= 1'b0;
         irdy_r   <= 1'b0;
         frame_r  <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         count_r  <= count_nxt;
         ad_vld_r <= ad_vld_nxt;
         irdy_r   <= irdy_nxt;
         frame_r  <= frame_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_r <= '0;
      end else if (go) begin
         fetch_r <= burst_len;
      end else if (fill) begin
         fetch_r <= fetch_r - ONE;
      end
   end

   // R07: next buffered QWORD and its byte enables onto the bus
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ad_r  <= '0;
         cbe_r <= 8'hFF;
      end else if (pop) begin
         ad_r  <= drain_data[63:0];
         cbe_r <= drain_data[71:64];
      end
   end

   // R12: completed last phase reports bus termination, normal end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= `ST_IDLE;
         end_r    <= `END_NONE;
      end else if (go) begin
         status_r <= `ST_DATA;
         end_r    <= `END_NONE;
      end else if (last_done) begin
         status_r <= `ST_BUS_TERM;
         end_r    <= `END_NORMAL;
      end
   end

   assign remaining_burst_count   = count_r;
   assign local_master_state_code = status_r;
   assign local_master_end_kind   = end_r;

   // R10: turnaround releases all but IRDY#, which is driven high once
   assign frame_n_o = !frame_r;
   assign frame_oe  = in_data;
   assign req64_n_o = !frame_r;
   assign req64_oe  = in_data;
   assign irdy_n_o  = !irdy_r;
   assign irdy_oe   = in_data || in_turn;
   assign ad_o      = ad_r;
   assign ad_oe     = in_data;
   assign cbe_n_o   = cbe_r;
   assign cbe_oe    = in_data;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_last_phase;
      in_data && irdy_r && last;
   endsequence

   sequence s_turn;
      in_turn && !frame_oe && !ad_oe && !cbe_oe && irdy_oe && irdy_n_o;
   endsequence

   chk_strobe_pair: assert property ( // R01
      local_low_half_taken_n == local_high_half_taken_n)
      else $error("half strobes differ");

   chk_strobe_idle: assert property ( // R02
      (!in_data || local_source_ready_n) |-> local_low_half_taken_n)
      else $error("strobe without a take");

   chk_frame_burst: assert property ( // R04
      (in_data && count_r > ONE) |-> !frame_n_o && frame_oe)
      else $error("FRAME# dropped mid burst");

   chk_count_step: assert property ( // R06
      (in_data && done && !last) |=> count_r == $past(count_r) - ONE)
      else $error("count not decremented");

   chk_ad_next: assert property ( // R07
      pop |=> ad_r == $past(drain_data[63:0]) && cbe_n_o == $past(drain_data[71:64]))
      else $error("AD not loaded from buffer");

   chk_irdy_hold: assert property ( // R08
      (irdy_r && !done) |=> irdy_r)
      else $error("IRDY# dropped before completion");

   chk_last_frame: assert property ( // R09
      s_last_phase |-> frame_n_o && req64_n_o && local_low_half_taken_n)
      else $error("final phase with FRAME# asserted");

   chk_turn_release: assert property ( // R10
      (in_data && last_done) |=> s_turn ##1 !irdy_oe)
      else $error("turnaround not released");

   chk_turn_zero: assert property ( // R11
      in_turn |-> count_r == '0)
      else $error("count not zero in turnaround");

   chk_term_status: assert property ( // R12
      last_done |=> local_master_state_code == `ST_BUS_TERM && local_master_end_kind == `END_NORMAL)
      else $error("termination status missing");

   chk_wide_claim: assert property ( // R14
      $rose(irdy_r) |-> $past(!ack64_s_n) && $past(!devsel_s_n))
      else $error("IRDY# without 64-bit claim");

   chk_start_load: assert property ( // R04
      go |=> in_data && frame_oe && !frame_n_o && count_r == $past(burst_len))
      else $error("burst start not loaded");

   chk_status_data: assert property ( // R12
      go |=> local_master_state_code == `ST_DATA && local_master_end_kind == `END_NONE)
      else $error("data status missing at start");

   chk_take_claim: assert property ( // R14
      !local_low_half_taken_n |-> in_data && !devsel_s_n && !ack64_s_n && fetch_r != '0)
      else $error("QWORD taken without a 64-bit claim");

   chk_irdy_data: assert property ( // R07
      irdy_r |-> ad_vld_r && ad_oe && cbe_oe)
      else $error("IRDY# without data on AD");

   chk_bus_released: assert property ( // R10
      (st_r == PH_IDLE) |-> !frame_oe && !req64_oe && !ad_oe && !cbe_oe && !irdy_oe)
      else $error("bus driven while idle");

   chk_phase_done: assert property ( // R05
      (irdy_r && !trdy_s_n && !last) |=> in_data && count_r != '0)
      else $error("completed phase ended the burst early");
endmodule

// ===== rtl/burst_wr_cfg.svh
// Purpose: constants for the 64-bit master burst write data phases
// Assumes: included by bare name
// Notes: status and end codes are local encodings
`ifndef BURST_WR_CFG_SVH
`define BURST_WR_CFG_SVH

`define SYNC_STAGES   2
`define SYNC_IDLE     1'b1
`define FIFO_DEPTH    2
`define CNT_WIDTH     8
`define ST_IDLE       4'h0
`define ST_DATA       4'h1
`define ST_BUS_TERM   4'h2
`define END_NONE      2'h0
`define END_NORMAL    2'h1

`endif

// ===== rtl/burst_wr_pkg.sv
// Purpose: types for the burst write data-phase sequencer
// Assumes: nothing
// Notes: phase enum only
package burst_wr_pkg;
   typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_TURN} phase_t;
endpackage

// ===== rtl/pin_sync.sv
// Purpose: two-flop synchroniser for bus pins
// Assumes: one bit per pin, idle level given by RST
// Notes: only the second stage is visible
`timescale 1ns/10ps
`include "burst_wr_cfg.svh"
module pin_sync #(
   parameter int         W   = 1,
   parameter logic       RST = `SYNC_IDLE
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // pins in, synchronised out
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   initial begin
      if (W < 1) $error("pin_sync: W must be at least 1");
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r <= RST;
               hold_r <= RST;
            end else begin
               meta_r <= d[i];
               hold_r <= meta_r;
            end
         end
         assign q[i] = hold_r;
      end
   endgenerate
endmodule

// ===== rtl/qword_fifo.sv
// Purpose: small FIFO between the local master and the AD drivers
// Assumes: DEPTH a power of two
// Notes: full and empty are exact
`timescale 1ns/10ps
`include "burst_wr_cfg.svh"
module qword_fifo #(
   parameter int W     = 72,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_vld,
   output      logic         in_rdy,
   input  wire logic [W-1:0] in_data,
   // drain side
   output      logic         out_vld,
   input  wire logic         out_rdy,
   output      logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("qword_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;

   wire          push = in_vld && in_rdy;
   wire          pop  = out_vld && out_rdy;
   wire          full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);

   assign in_rdy   = !full;
   assign out_vld  = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (push) mem[wr_r[AW-1:0]] <= in_data;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop)  rd_r <= rd_r + 1'b1;
      end
   end
endmodule

// ===== sim/pci_target_model.sv
// Purpose: behavioural target that claims 64-bit write bursts
// Assumes: one burst at a time, master pins seen directly
// Notes: the claim waits wait_clks clocks before the ready signal is given
`timescale 1ns/10ps
module pci_target_model (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // master pins
   input  wire logic       frame_n_o,
   input  wire logic       frame_oe,
   // pacing
   input  wire logic [3:0] wait_clks,
   // target pins
   output      logic       trdy_n,
   output      logic       devsel_n,
   output      logic       ack64_n
);
   logic [3:0] cnt_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r    <= 4'h0;
         devsel_n <= 1'b1;
         ack64_n  <= 1'b1;
         trdy_n   <= 1'b1;
      end else if (!frame_oe) begin
         cnt_r    <= 4'h0;
         devsel_n <= 1'b1;
         ack64_n  <= 1'b1;
         trdy_n   <= 1'b1;
      end else if (!frame_n_o || !devsel_n) begin
         devsel_n <= 1'b0;
         ack64_n  <= 1'b0;
         if (cnt_r >= wait_clks) begin
            trdy_n <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the burst write data phases
// Assumes: the target model answers on the far side
// Notes: the local master is driven here, with random stalls
`timescale 1ns/10ps
`include "burst_wr_cfg.svh"
module tb
   import burst_wr_pkg::*;
;
   logic        mclk, rst_n, start, ready_n, lo_n, hi_n, frame_n, frame_oe, req64_n, req64_oe;
   logic        irdy_n, irdy_oe, ad_oe, cbe_oe, trdy_n, devsel_n, ack64_n, lstall, active;
   logic [7:0]  burst_len, be_in, cbe_n, count, cnt_seen;
   logic [63:0] data_in, ad;
   logic [3:0]  state, wait_clks;
   logic [1:0]  end_kind;
   logic [71:0] words [0:15];
   logic [71:0] held;
   int          miscompares, n_checks, seed, len_g, ptr, phases, k;

   burst_wr_phase i_burst_wr_phase (.mclk(mclk), .rst_n(rst_n), .start(start), .burst_len(burst_len),
      .local_source_ready_n(ready_n), .local_data_in(data_in), .local_byte_enables_in(be_in),
      .local_low_half_taken_n(lo_n), .local_high_half_taken_n(hi_n), .remaining_burst_count(count),
      .local_master_state_code(state), .local_master_end_kind(end_kind), .frame_n_o(frame_n),
      .frame_oe(frame_oe), .req64_n_o(req64_n), .req64_oe(req64_oe), .irdy_n_o(irdy_n),
      .irdy_oe(irdy_oe), .ad_o(ad), .ad_oe(ad_oe), .cbe_n_o(cbe_n), .cbe_oe(cbe_oe),
      .trdy_n_i(trdy_n), .devsel_n_i(devsel_n), .ack64_n_i(ack64_n));

   pci_target_model i_pci_target_model (.mclk(mclk), .rst_n(rst_n), .frame_n_o(frame_n),
      .frame_oe(frame_oe), .wait_clks(wait_clks), .trdy_n(trdy_n), .devsel_n(devsel_n), .ack64_n(ack64_n));

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic logic [71:0] exp_word(input int i);
      return words[i % 16];
   endfunction

   always @(posedge mclk) begin
      if (active) begin
         if (!ready_n && !lo_n) begin
            ptr = ptr + 1;
         end
         if (ready_n || !lo_n) begin
            ready_n          <= (ptr >= len_g) || (lstall && ($random(seed) % 2 != 0));
            {data_in, be_in} <= exp_word(ptr);
         end
      end
   end

   always @(negedge mclk) begin
      if (active) begin
         chk(72'(lo_n), 72'(hi_n));
         if (cnt_seen != 8'h00 && count !== cnt_seen) begin
            chk(72'(count), 72'(cnt_seen - 8'h01));
            chk(held, exp_word(phases));
            phases++;
         end
         if (state === `ST_DATA && frame_oe === 1'b1 && count > 8'h01) begin
            chk(72'({frame_n, req64_n}), 72'h0);
         end
      end
      cnt_seen = count;
      held     = {ad, cbe_n};
   end

   task automatic run_burst(input int len, input logic ls, input logic [3:0] ws);
      int i;
      for (i = 0; i < 16; i++) begin
         words[i] = {32'($random(seed)), 32'($random(seed)), 8'($random(seed))};
      end
      @(negedge mclk);
      len_g     = len;
      ptr       = 0;
      phases    = 0;
      lstall    = ls;
      wait_clks = ws;
      active    = 1'b1;
      @(posedge mclk);
      start     <= 1'b1;
      burst_len <= 8'(len);
      @(posedge mclk);
      start     <= 1'b0;
      @(negedge mclk);
      chk(72'({frame_oe, frame_n, count}), 72'({1'b1, 1'b0, 8'(len)}));
      i = 0;
      while (state !== `ST_BUS_TERM && i < 300) begin
         @(negedge mclk);
         i++;
      end
      chk(72'({frame_oe, req64_oe, ad_oe, cbe_oe, irdy_n}), 72'h01);
      chk(72'(count), 72'h0);
      chk(72'({state, end_kind}), 72'({`ST_BUS_TERM, `END_NORMAL}));
      repeat (2) @(negedge mclk);
      active = 1'b0;
      chk(72'(phases), 72'(len));
      chk(72'(ptr), 72'(len));
      chk(72'({state, irdy_oe, lo_n, hi_n}), 72'({`ST_BUS_TERM, 1'b0, 1'b1, 1'b1}));
   endtask

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      seed      = 29212;
      rst_n     = 1'b0;
      start     = 1'b0;
      burst_len = 8'h00;
      ready_n   = 1'b1;
      data_in   = 64'h0;
      be_in     = 8'hFF;
      wait_clks = 4'h0;
      active    = 1'b0;
      lstall    = 1'b0;
      cnt_seen  = 8'h00;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      // zero length start is ignored
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      repeat (2) @(negedge mclk);
      chk(72'({state, frame_oe}), 72'({`ST_IDLE, 1'b0}));
      run_burst(1, 1'b0, 4'h0);
      run_burst(2, 1'b0, 4'h0);
      run_burst(5, 1'b1, 4'h3);
      run_burst(16, 1'b1, 4'h0);
      for (k = 0; k < 8; k++) begin
         run_burst(($random(seed) & 15) + 1, 1'($random(seed)), 4'($random(seed) & 7));
      end
      report_and_stop();
   end
endmodule
